// ---- rtl/light_sensor_pkg.sv ----
// Shared constants, register layout, mode codes and state types for the light sensor slave.
// Assumes a single 40 MHz system clock; the serial bus pins arrive asynchronously.
package light_sensor_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;
  localparam int unsigned POWERUP_NS     = 10_000;
  localparam int unsigned POWERUP_CYCLES = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned COMMIT_NS      = 1_000;
  localparam int unsigned COMMIT_CYCLES  = (COMMIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_MS        = 90;
  localparam int unsigned CONV_DEFAULT   = CONV_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W          = 16;
  localparam int unsigned CONV_W         = 32;

  // ----------------------------------------------------------------
  // Bus address and register map
  // ----------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h44;
  localparam int unsigned NUM_REGS     = 9;
  localparam logic [3:0] REG_CMD1      = 4'h0;
  localparam logic [3:0] REG_CMD2      = 4'h1;
  localparam logic [3:0] REG_DATA_L    = 4'h2;
  localparam logic [3:0] REG_DATA_H    = 4'h3;
  localparam logic [3:0] REG_LO_L      = 4'h4;
  localparam logic [3:0] REG_LO_H      = 4'h5;
  localparam logic [3:0] REG_HI_L      = 4'h6;
  localparam logic [3:0] REG_HI_H      = 4'h7;
  localparam logic [3:0] REG_LAST      = 4'h8;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [7:0] THR_HI_RESET  = 8'hFF;

  // Field positions.
  localparam int unsigned OP_MSB   = 7;
  localparam int unsigned OP_LSB   = 5;
  localparam int unsigned FLAG_BIT = 2;
  localparam int unsigned PERS_MSB = 1;
  localparam int unsigned PERS_LSB = 0;
  localparam int unsigned RES_MSB  = 3;
  localparam int unsigned RES_LSB  = 2;
  localparam int unsigned CTRL2_MSB = 3;

  // Result width masks for resolution codes 16, 12, 8 and 4 bits.
  localparam logic [15:0] RES_MASK_16 = 16'hFFFF;
  localparam logic [15:0] RES_MASK_12 = 16'h0FFF;
  localparam logic [15:0] RES_MASK_8  = 16'h00FF;
  localparam logic [15:0] RES_MASK_4  = 16'h000F;

  // Persistence counts.
  localparam logic [4:0] PERS_N0 = 5'h01;
  localparam logic [4:0] PERS_N1 = 5'h04;
  localparam logic [4:0] PERS_N2 = 5'h08;
  localparam logic [4:0] PERS_N3 = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OFF      = 3'b000,
    OP_VIS_ONCE = 3'b001,
    OP_IR_ONCE  = 3'b010,
    OP_VIS_CONT = 3'b101,
    OP_IR_CONT  = 3'b110
  } op_mode_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_ADDR   = 4'b0001,
    ST_AACK   = 4'b0010,
    ST_REG    = 4'b0011,
    ST_REGACK = 4'b0100,
    ST_WDATA  = 4'b0101,
    ST_WACK   = 4'b0110,
    ST_RDATA  = 4'b0111,
    ST_MACK   = 4'b1000,
    ST_IGNORE = 4'b1001
  } i2c_st_t;

  typedef struct packed {
    logic [15:0] vis;
    logic [15:0] ir;
  } light_sample_t;

  typedef struct packed {
    logic                         scl_s1;
    logic                         scl_s2;
    logic                         scl_s3;
    logic                         sda_s1;
    logic                         sda_s2;
    logic                         sda_s3;
    i2c_st_t                      st;
    logic [3:0]                   bitcnt;
    logic [7:0]                   shreg;
    logic [3:0]                   ptr;
    logic [3:0]                   last_wr;
    logic                         wrote;
    logic                         rw;
    logic                         mack;
    logic                         sda_oe;
    logic [CNT_W-1:0]             pwr_cnt;
    logic [CNT_W-1:0]             commit_cnt;
    logic [CONV_W-1:0]            conv_cnt;
    logic [4:0]                   pers_cnt;
    logic [NUM_REGS-1:0][7:0]     regs;
  } state_t;

endpackage

// ---- rtl/light_sensor_i2c_slave.sv ----
// Two-wire serial slave, register array and measurement sequencer of a light sensor.
// Assumes scl_i and sda_i come straight from pins and the sample port from the same clock.
//
// Function
// - Starts powered down; result registers read zero after reset.
// - One-shot mode converts once, then returns to power-down keeping the result.
// - Continuous mode converts back to back, overwriting results until power-down.
// - Four modes: visible once, infrared once, visible continuous, infrared continuous.
// - Operation field codes 000, 001, 010, 101, 110; 011, 100 and 111 reserved.
// - Result is unsigned with selectable width up to sixteen bits.
// - Open-drain low interrupt when result leaves the threshold window.
// - Conversions continue after the interrupt asserts.
// - Interrupt needs the selected persistence count of consecutive out-of-window results before asserting.
// - Persistence codes 00, 01, 10, 11 give 1, 4, 8, 16 cycles.
// - Interrupt and flag hold until a read of register zero completes.
// - Bytes travel most significant bit first in both directions.
// - Ignore traffic until a start; ignore starts during power-up.
// - Stop after a completed transaction returns the serial logic to standby.
// - Stop before byte and acknowledge complete aborts without touching registers.
// - Acknowledge matching address, register address and each written data byte.
// - Compare upper seven address bits with the fixed address; acknowledge on match.
// - Address byte lowest bit: one reads, zero writes.
// - After a write stop, commit with data line released and requests ignored.
// - Burst write acknowledges each byte and advances the pointer by one.
// - Pointer wraps from the last register to the first.
// - After a write ends, pointer holds the last written address.
// - Device keeps sending while the master acknowledges; master ends with no ack.
module light_sensor_i2c_slave
  import light_sensor_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = light_sensor_pkg::CONV_DEFAULT
) (
  input  wire logic                            clk_sys,
  input  wire logic                            resetn,
  input  wire logic                            scl_i,
  input  wire logic                            sda_i,
  output logic                                 sda_o,
  output logic                                 sda_oe,
  output logic                                 int_n_o,
  output logic                                 int_n_oe,
  input  wire light_sensor_pkg::light_sample_t sample,
  output logic                                 measuring
);
  import light_sensor_pkg::*;

  // ----------------------------------------------------------------
  // State and decoded bus events
  // ----------------------------------------------------------------
  state_t      q;
  state_t      d;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_c;
  logic        stop_c;
  logic        blocked;
  logic        running;
  logic        once;
  logic        conv_done;
  logic        set_flag;
  logic        clr_flag;
  logic        wr_en;
  logic [15:0] mask;
  logic [15:0] result;
  logic [15:0] thr_lo;
  logic [15:0] thr_hi;
  logic [4:0]  pers_n;
  logic [2:0]  op;
  logic [3:0]  ptr_inc;

  // Edges come from the second and third stages only; the first stage feeds nothing else.
  assign scl_rise = q.scl_s2 & ~q.scl_s3;
  assign scl_fall = ~q.scl_s2 & q.scl_s3;
  assign start_c  = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
  assign stop_c   = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
  assign blocked  = (q.pwr_cnt != '0) || (q.commit_cnt != '0);
  assign op       = q.regs[REG_CMD1][OP_MSB:OP_LSB];
  assign thr_lo   = {q.regs[REG_LO_H], q.regs[REG_LO_L]};
  assign thr_hi   = {q.regs[REG_HI_H], q.regs[REG_HI_L]};

  assign running  = (op == OP_VIS_ONCE) || (op == OP_IR_ONCE) ||
                    (op == OP_VIS_CONT) || (op == OP_IR_CONT);
  assign once     = (op == OP_VIS_ONCE) || (op == OP_IR_ONCE);
  assign conv_done = running && (q.conv_cnt == CONV_W'(CONV_CYCLES - 1));

  always_comb begin
    unique case (q.regs[REG_CMD2][RES_MSB:RES_LSB])
      2'b00: mask = RES_MASK_16;
      2'b01: mask = RES_MASK_12;
      2'b10: mask = RES_MASK_8;
      2'b11: mask = RES_MASK_4;
    endcase
  end

  always_comb begin
    unique case (q.regs[REG_CMD1][PERS_MSB:PERS_LSB])
      2'b00: pers_n = PERS_N0;
      2'b01: pers_n = PERS_N1;
      2'b10: pers_n = PERS_N2;
      2'b11: pers_n = PERS_N3;
    endcase
  end

  assign result = (op[1] ? sample.ir : sample.vis) & mask;

  assign ptr_inc = (q.ptr >= REG_LAST) ? REG_CMD1 : 4'(q.ptr + 4'h1);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // One process holds the sequencer and the serial engine so that a register write and a
  // conversion landing in the same cycle resolve in a single, visible order.
  always_comb begin
    logic [7:0] tx;
    tx        = REG_RESET;
    d         = q;
    set_flag  = 1'b0;
    clr_flag  = 1'b0;
    wr_en     = 1'b0;
    d.scl_s1  = scl_i;
    d.scl_s2  = q.scl_s1;
    d.scl_s3  = q.scl_s2;
    d.sda_s1  = sda_i;
    d.sda_s2  = q.sda_s1;
    d.sda_s3  = q.sda_s2;
    d.pwr_cnt    = (q.pwr_cnt != '0) ? CNT_W'(q.pwr_cnt - 1'b1) : q.pwr_cnt;
    d.commit_cnt = (q.commit_cnt != '0) ? CNT_W'(q.commit_cnt - 1'b1) : q.commit_cnt;

    if (!running) begin
      d.conv_cnt = '0;
    end else if (conv_done) begin
      d.conv_cnt = '0;
      d.regs[REG_DATA_L] = result[7:0];
      d.regs[REG_DATA_H] = result[15:8];
      if ((result > thr_hi) || (result < thr_lo)) begin
        if (5'(q.pers_cnt + 5'h01) >= pers_n) begin
          set_flag   = 1'b1;
          d.pers_cnt = pers_n;
        end else begin
          d.pers_cnt = 5'(q.pers_cnt + 5'h01);
        end
      end else begin
        d.pers_cnt = '0;
      end
      if (once) begin
        d.regs[REG_CMD1][OP_MSB:OP_LSB] = OP_OFF;
      end
    end else begin
      d.conv_cnt = 32'(q.conv_cnt + 1'b1);
    end

    if (stop_c) begin
      d.st     = ST_IDLE;
      d.sda_oe = 1'b0;
      if (q.wrote) begin
        d.ptr = q.last_wr;
        d.commit_cnt = CNT_W'(COMMIT_CYCLES);
      end
      d.wrote = 1'b0;
    end else if (start_c) begin
      d.sda_oe = 1'b0;
      d.bitcnt = '0;
      d.st     = blocked ? ST_IDLE : ST_ADDR;
    end else if (scl_rise) begin
      unique case (q.st)
        ST_ADDR, ST_REG, ST_WDATA, ST_RDATA: begin
          d.shreg  = (q.st == ST_RDATA) ? q.shreg : {q.shreg[6:0], q.sda_s2};
          d.bitcnt = 4'(q.bitcnt + 4'h1);
        end
        ST_MACK: begin
          d.mack = ~q.sda_s2;
          if (q.ptr == REG_CMD1) begin
            clr_flag = 1'b1;
          end
          d.ptr = ptr_inc;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (q.st)
        ST_ADDR: begin
          if (q.bitcnt == 4'h8) begin
            if (q.shreg[7:1] == DEV_ADDR) begin
              d.sda_oe = 1'b1;
              d.rw     = q.shreg[0];
              d.st     = ST_AACK;
            end else begin
              d.sda_oe = 1'b0;
              d.st     = ST_IGNORE;
            end
          end
        end
        ST_REG, ST_WDATA: begin
          if (q.bitcnt == 4'h8) begin
            d.sda_oe = 1'b1;
            d.st     = (q.st == ST_REG) ? ST_REGACK : ST_WACK;
          end
        end
        ST_AACK, ST_MACK: begin
          d.bitcnt = '0;
          if ((q.st == ST_AACK && q.rw) || (q.st == ST_MACK && q.mack)) begin
            tx       = (q.ptr <= REG_LAST) ? q.regs[q.ptr] : REG_RESET;
            d.shreg  = tx;
            d.sda_oe = ~tx[7];
            d.st     = ST_RDATA;
          end else begin
            d.sda_oe = 1'b0;
            d.st     = (q.st == ST_AACK) ? ST_REG : ST_IGNORE;
          end
        end
        ST_REGACK: begin
          d.ptr    = (q.shreg > 8'(REG_LAST)) ? REG_CMD1 : q.shreg[3:0];
          d.sda_oe = 1'b0;
          d.bitcnt = '0;
          d.st     = ST_WDATA;
        end
        ST_WACK: begin
          wr_en     = 1'b1;
          d.last_wr = q.ptr;
          d.wrote   = 1'b1;
          d.ptr     = ptr_inc;
          d.sda_oe  = 1'b0;
          d.bitcnt  = '0;
          d.st      = ST_WDATA;
          unique case (q.ptr)
            REG_CMD1: begin
              d.regs[REG_CMD1] = {q.shreg[OP_MSB:OP_LSB], 2'b00, q.regs[REG_CMD1][FLAG_BIT],
                                  q.shreg[PERS_MSB:PERS_LSB]};
              d.conv_cnt = '0;
              d.pers_cnt = '0;
            end
            REG_CMD2: d.regs[REG_CMD2] = {4'h0, q.shreg[CTRL2_MSB:0]};
            REG_LO_L, REG_LO_H, REG_HI_L, REG_HI_H: d.regs[q.ptr] = q.shreg;
            default: begin
            end
          endcase
        end
        ST_RDATA: begin
          if (q.bitcnt == 4'h8) begin
            d.sda_oe = 1'b0;
            d.st     = ST_MACK;
          end else begin
            d.shreg  = {q.shreg[6:0], 1'b0};
            d.sda_oe = ~q.shreg[6];
          end
        end
        default: begin
        end
      endcase
    end

    d.regs[REG_CMD1][FLAG_BIT] = set_flag | (q.regs[REG_CMD1][FLAG_BIT] & ~clr_flag);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // powered-down reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      q                  <= '0;
      // Idle lines are high; resetting the stages high avoids a false start at release.
      {q.scl_s1, q.scl_s2, q.scl_s3} <= 3'h7;
      {q.sda_s1, q.sda_s2, q.sda_s3} <= 3'h7;
      q.pwr_cnt          <= CNT_W'(POWERUP_CYCLES);
      q.regs[REG_HI_L]   <= THR_HI_RESET;
      q.regs[REG_HI_H]   <= THR_HI_RESET;
    end else begin
      q <= d;
    end
  end

  // Pins are open drain: only low is ever driven.
  assign sda_o     = 1'b0;
  assign sda_oe    = q.sda_oe;
  assign int_n_o   = 1'b0;
  assign int_n_oe  = q.regs[REG_CMD1][FLAG_BIT];
  assign measuring = running;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_once_off;
    @(posedge clk_sys) disable iff (!resetn)
      (conv_done && once && !wr_en) |=> (op == OP_OFF) &&
        ({q.regs[REG_DATA_H], q.regs[REG_DATA_L]} == $past(result));
  endproperty
  a_once_off: assert property (p_once_off) else $error("one-shot did not stop");
  property p_cont_keeps;
    @(posedge clk_sys) disable iff (!resetn)
      (conv_done && !once && !wr_en) |=> (op == $past(op)) && (q.conv_cnt == '0);
  endproperty
  a_cont_keeps: assert property (p_cont_keeps) else $error("continuous mode lost");
  property p_int_follows;
    @(posedge clk_sys) disable iff (!resetn)
      set_flag |=> int_n_oe;
  endproperty
  a_int_follows: assert property (p_int_follows) else $error("interrupt not raised");
  property p_flag_holds;
    @(posedge clk_sys) disable iff (!resetn)
      (int_n_oe && !clr_flag) |=> int_n_oe;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("interrupt dropped early");
  property p_addr_ack;
    @(posedge clk_sys) disable iff (!resetn)
      (q.st == ST_ADDR && scl_fall && !stop_c && !start_c && q.bitcnt == 4'h8 &&
       q.shreg[7:1] == DEV_ADDR) |=> sda_oe ##1 (sda_oe || q.st != ST_AACK);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
  property p_mismatch;
    @(posedge clk_sys) disable iff (!resetn)
      (q.st == ST_IGNORE && !start_c) |=> !sda_oe;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("drove line when ignoring");
  property p_start_blocked;
    @(posedge clk_sys) disable iff (!resetn)
      (start_c && !stop_c && blocked) |=> (q.st == ST_IDLE) && !sda_oe;
  endproperty
  a_start_blocked: assert property (p_start_blocked) else $error("start taken when busy");
  property p_stop_abort;
    @(posedge clk_sys) disable iff (!resetn)
      stop_c |=> ({q.regs[REG_HI_H], q.regs[REG_HI_L], q.regs[REG_LO_H], q.regs[REG_LO_L]}
                  == $past({q.regs[REG_HI_H], q.regs[REG_HI_L], q.regs[REG_LO_H],
                            q.regs[REG_LO_L]})) && (q.st == ST_IDLE);
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop altered registers");
  property p_commit_quiet;
    @(posedge clk_sys) disable iff (!resetn)
      (q.commit_cnt != '0) |-> !sda_oe;
  endproperty
  a_commit_quiet: assert property (p_commit_quiet) else $error("drove line in commit");
  property p_wrap;
    @(posedge clk_sys) disable iff (!resetn)
      (wr_en && q.ptr == REG_LAST && !stop_c) |=> (q.ptr == REG_CMD1);
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

endmodule

// ---- bench/i2c_master_model.sv ----
// Two-wire bus master model: drives the serial clock and pulls the data line.
// Assumes the bench resolves the open-drain data line and returns it on sda.
module i2c_master_model (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl     = 1'b1,
  output logic      sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;

  // Waits whole system clocks; a bus half period is four of them.
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // start framing.
  // The data line rises first so that a repeated start also works.
  task automatic start();
    sda_low <= 1'b0;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b1;
    tk(4);
    scl <= 1'b0;
    tk(2);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    tk(2);
    scl <= 1'b1;
    tk(4);
    sda_low <= 1'b0;
    tk(4);
  endtask

  // data steady high.
  // Data only changes while the clock is low; the line is sampled mid-high.
  task automatic clk_bit(input logic b, output logic seen);
    sda_low <= !b;
    tk(2);
    scl <= 1'b1;
    tk(2);
    seen = sda;
    tk(2);
    scl <= 1'b0;
    tk(2);
  endtask

  // msb first.
  // Fewer than eight bits leaves the byte unfinished for abort tests.
  task automatic put_byte(input logic [7:0] d, input int nbits, output logic ack);
    logic s;
    for (int i = 7; i > 7 - nbits; i--) clk_bit(d[i], s);
    if (nbits == 8) clk_bit(1'b1, s);
    ack = !s;
  endtask

  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(last, s);
  endtask
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the light sensor serial slave.
// Assumes the master model in this folder and a 40 MHz system clock.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import light_sensor_pkg::*;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_t;
  localparam row_t ROWS [9] = '{'{8'h04, 8'hA5, 8'hA5}, '{8'h05, 8'h3C, 8'h3C},
    '{8'h06, 8'h12, 8'h12}, '{8'h01, 8'hFF, 8'h0F}, '{8'h01, 8'h00, 8'h00},
    '{8'h02, 8'h77, 8'h00}, '{8'h08, 8'h55, 8'h00}, '{8'h00, 8'h1F, 8'h03},
    '{8'h0C, 8'h02, 8'h02}};
  localparam logic [7:0] RV [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF,
    8'hFF, 8'h00, 8'h00};
  localparam logic [7:0] OPS [4] = '{8'h20, 8'h40, 8'hA0, 8'hC0};
  localparam logic [7:0] RES [4] = '{8'h08, 8'h0C, 8'h00, 8'h04};

  logic          clk_sys = 1'b0;
  logic          resetn  = 1'b0;
  logic          scl;
  logic          m_low;
  logic          sda_line;
  logic          sda_o;
  logic          sda_oe;
  logic          int_n_o;
  logic          int_n_oe;
  logic          measuring;
  light_sample_t sample  = '0;
  logic [7:0]    rb [16];
  int            fail_count = 0;
  int            n_checks   = 0;

  // The data line is pulled up unless either party pulls it low.
  assign sda_line = !(m_low || sda_oe);

  always #12.5 clk_sys = ~clk_sys;

  i2c_master_model m_u (.clk_sys(clk_sys), .sda(sda_line), .scl(scl), .sda_low(m_low));

  // A short conversion keeps the run brief; the waits for conversion results below follow it.
  light_sensor_i2c_slave #(.CONV_CYCLES(50)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
    .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .int_n_o(int_n_o),
    .int_n_oe(int_n_oe), .sample(sample), .measuring(measuring));

  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic check(input string w, input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", w, e, s);
    end
  endtask

  // Write transaction; gap covers the commit time before the next start.
  task automatic wr(input logic [7:0] a, input logic [7:0] d [$], input int gap = 50);
    logic k;
    m_u.start();
    m_u.put_byte({DEV_ADDR, 1'b0}, 8, k);
    check("addr ack", 8'(k), 8'h01);
    m_u.put_byte(a, 8, k);
    check("reg ack", 8'(k), 8'h01);
    foreach (d[i]) begin
      m_u.put_byte(d[i], 8, k);
      check("data ack", 8'(k), 8'h01);
    end
    m_u.stop();
    tk(gap);
  endtask

  // Read transaction, optionally setting the pointer first.
  task automatic rd(input logic [7:0] a, input int n, input bit setp = 1'b1);
    logic k;
    if (setp) begin
      m_u.start();
      m_u.put_byte({DEV_ADDR, 1'b0}, 8, k);
      m_u.put_byte(a, 8, k);
    end
    m_u.start();
    m_u.put_byte({DEV_ADDR, 1'b1}, 8, k);
    check("read ack", 8'(k), 8'h01);
    for (int i = 0; i < n; i++) m_u.get_byte(i == n - 1, rb[i]);
    m_u.stop();
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short; the full sequence needs well under this span.
  initial begin
    tk(60000);
    fail_count++;
    results();
  end

  // Main sequence: power-up and reset values, then table rows, the awkward cases, a reset and the interrupt cases.
  initial begin
    logic        k;
    logic [15:0] v;
    tk(10);
    resetn <= 1'b1;
    m_u.start();
    m_u.put_byte({DEV_ADDR, 1'b0}, 8, k);
    check("powerup ack", 8'(k), 8'h00);
    m_u.stop();
    tk(400);
    rd(8'h00, 10);
    foreach (RV[i]) check("reset value", rb[i], RV[i]);
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, '{ROWS[i].d});
      rd(ROWS[i].a, 1);
      check("row", rb[0], ROWS[i].e);
    end
    m_u.start();
    m_u.put_byte(8'h90, 8, k);
    check("foreign addr", 8'(k), 8'h00);
    m_u.put_byte(8'h04, 8, k);
    check("ignored byte", 8'(k), 8'h00);
    m_u.stop();
    wr(8'h07, '{8'h11, 8'h22, 8'h02});
    rd(8'h00, 1, 1'b0);
    check("last pointer", rb[0], 8'h02);
    rd(8'h07, 1);
    check("burst write", rb[0], 8'h11);
    m_u.start();
    m_u.put_byte({DEV_ADDR, 1'b0}, 8, k);
    m_u.put_byte(8'h04, 8, k);
    m_u.put_byte(8'hEE, 4, k);
    m_u.stop();
    rd(8'h04, 1);
    check("aborted write", rb[0], 8'hA5);
    wr(8'h05, '{8'h3C}, 0);
    m_u.start();
    m_u.put_byte({DEV_ADDR, 1'b0}, 8, k);
    check("commit busy", 8'(k), 8'h00);
    m_u.stop();
    tk(50);
    sample <= '{vis: 16'h1234, ir: 16'hABCD};
    foreach (OPS[i]) begin
      wr(8'h01, '{RES[i]});
      wr(8'h00, '{OPS[i]});
      tk(60);
      rd(8'h02, 2);
      v = (OPS[i][6] ? sample.ir : sample.vis) & (16'hFFFF >> (4 * RES[i][3:2]));
      check("result lo", rb[0], v[7:0]);
      check("result hi", rb[1], v[15:8]);
      check("running", 8'(measuring), 8'(OPS[i][7]));
    end
    sample <= '{vis: 16'h1234, ir: 16'h5A5A};
    tk(60);
    rd(8'h02, 2);
    check("overwrite lo", rb[0], 8'h5A);
    check("overwrite hi", rb[1], 8'h0A);
    wr(8'h00, '{8'h00});
    check("stopped", 8'(measuring), 8'h00);
    // Mid-run reset: the flag is up from the inverted window above, results are non-zero.
    check("int before reset", 8'(int_n_oe), 8'h01);
    resetn <= 1'b0;
    tk(10);
    check("reset int", 8'(int_n_oe), 8'h00);
    check("reset sda", 8'(sda_oe), 8'h00);
    resetn <= 1'b1;
    tk(420);
    rd(8'h02, 2);
    check("reset result lo", rb[0], 8'h00);
    check("reset result hi", rb[1], 8'h00);
    wr(8'h04, '{8'h00, 8'h10, 8'h00, 8'h20});
    rd(8'h00, 1);
    check("int idle", 8'(int_n_oe), 8'h00);
    sample <= '{vis: 16'h1800, ir: 16'h0000};
    wr(8'h00, '{8'h21});
    tk(60);
    sample <= '{vis: 16'h3000, ir: 16'h0000};
    wr(8'h00, '{8'hA1}, 0);
    tk(130);
    check("int early", 8'(int_n_oe), 8'h00);
    tk(130);
    check("int fired", 8'(int_n_oe), 8'h01);
    check("still converting", 8'(measuring), 8'h01);
    check("int drive", 8'(int_n_o), 8'h00);
    wr(8'h00, '{8'h01});
    rd(8'h00, 1);
    check("flag", rb[0], 8'h05);
    check("int cleared", 8'(int_n_oe), 8'h00);
    // Persistence of eight: the seventh result must not fire, the eighth must.
    wr(8'h00, '{8'hA2}, 0);
    tk(370);
    check("int at seven", 8'(int_n_oe), 8'h00);
    tk(60);
    check("int at eight", 8'(int_n_oe), 8'h01);
    check("data drive", 8'(sda_o), 8'h00);
    results();
  end
endmodule
